// ===== rtl/lcd_io_pkg.sv
// constants, register map and pin tables for the lcd shared i/o ports
// assumes a 32-bit avalon-mm slave with byte addresses, one register per word
package lcd_io_pkg;

   // ==================================================================
   // register indices (byte address is four times the index)
   localparam logic [8:0] IDX_PORT_D_PINS      = 9'h008;
   localparam logic [8:0] IDX_PORT_E_PINS      = 9'h009;
   localparam logic [8:0] IDX_PORT_D_DIRECTION = 9'h088;
   localparam logic [8:0] IDX_PORT_E_DIRECTION = 9'h089;
   localparam logic [8:0] IDX_PORT_F_PINS      = 9'h107;
   localparam logic [8:0] IDX_PORT_G_PINS      = 9'h108;
   localparam logic [8:0] IDX_SEGMENT_PIN_EN   = 9'h10D;
   localparam logic [8:0] IDX_PORT_F_DIRECTION = 9'h187;
   localparam logic [8:0] IDX_PORT_G_DIRECTION = 9'h188;

   // ==================================================================
   // reset values
   localparam logic [7:0] RST_PINS_LATCH = 8'h00;
   localparam logic [7:0] RST_DIRECTION  = 8'hFF;
   localparam logic [7:0] RST_SEG_ENABLE = 8'hFF;

   // ==================================================================
   // port numbering inside the 32-bit pin vector (pin = port * 8 + bit)
   localparam int PORT_D = 0;
   localparam int PORT_E = 1;
   localparam int PORT_F = 2;
   localparam int PORT_G = 3;
   localparam int PIN_COUNT = 32;
   localparam int BIDIR_PINS = 5;     // port d bits 0..4
   localparam int COM_PIN_BASE = 5;   // port d bits 5..7 may be commons

   // ==================================================================
   // segment-enable bit that owns each pin, pin 31 first
   localparam logic [31:0][2:0] PIN_GROUP = {
      3'h6, {7{3'h5}},                       // g7 seg28, g6..g0 seg26..20
      {4{3'h4}}, {4{3'h3}},                  // f7..f4 seg19..16, f3..f0
      3'h6, {3{3'h2}}, {4{3'h1}},            // e7 seg27, e6..e4, e3..e0
      {3{3'h7}}, {5{3'h0}}                   // d7..d5 seg31..29, d4..d0
   };

   // segment driver number on each pin, pin 31 first
   localparam logic [31:0][4:0] PIN_SEGMENT = {
      5'h1C, 5'h1A, 5'h19, 5'h18, 5'h17, 5'h16, 5'h15, 5'h14,
      5'h13, 5'h12, 5'h11, 5'h10, 5'h0F, 5'h0E, 5'h0D, 5'h0C,
      5'h1B, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05,
      5'h1F, 5'h1E, 5'h1D, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00
   };

   // common driver number on port d bits 7..5 (d5 com3, d6 com2, d7 com1)
   localparam logic [2:0][1:0] PIN_COMMON = {2'h1, 2'h2, 2'h3};

   // ==================================================================
   // avalon response codes
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==================================================================
   // carried bundles
   typedef struct packed {
      logic [31:0] lane;    // one bit per pin
   } pin_vec_t;

   typedef struct packed {
      logic [3:0][7:0] direction;
      logic [3:0][7:0] latch;
      logic [7:0]      seg_en;
      logic [31:0]     sync1;
      logic [31:0]     sync2;
      logic            waitreq;
      logic [31:0]     rdata;
      logic [1:0]      resp;
      logic [31:0]     pin_out;
      logic [31:0]     pin_oe;
      logic [31:0]     lcd_owned;
   } state_t;

endpackage

// ===== rtl/lcd_shared_io_ports.sv
// ports d, e, f and g with pins shared between digital i/o and lcd drivers
// assumes the lcd timing logic runs on I_MCLK; pins are asynchronous
// Function
// RULE1: d0-d4 bidirectional or segments 0-4
// RULE2: d5-d7 input or seg29-31/com3-1
// RULE3: port e input or seg5-11, seg27
// RULE4: port f input or segments 12-19
// RULE5: port g input or seg20-26, seg28
// RULE6: after reset all shared pins are lcd
// RULE7: set enable bit overrides direction bits
// RULE8: software clears enable before digital use
// RULE9: enable register 8 bits, resets ones
// RULE10: clearing 27,5,9 frees e and g7
// RULE11: clearing 27,20 frees g and e7
// RULE12: direction registers reset to all ones
// RULE13: data latches reset to all zeros
// RULE14: data read returns pin levels
// RULE15: data write stores the output latch
// RULE16: bit-modify copies pin levels into latch
// RULE17: d direction only acts in digital mode
// RULE18: direction set input, clear drives latch
// RULE19: input-only pins never drive latch
`timescale 1ns/100ps
`default_nettype none

module lcd_shared_io_ports #(
   parameter int ADDR_WIDTH = 11
) (
   // clock and reset
   input  wire logic                  I_MCLK,
   input  wire logic                  I_NRST,
   // avalon-mm slave
   input  wire logic [ADDR_WIDTH-1:0] I_AVS_ADDRESS,
   input  wire logic                  I_AVS_READ,
   input  wire logic                  I_AVS_WRITE,
   input  wire logic [31:0]           I_AVS_WRITEDATA,
   input  wire logic [3:0]            I_AVS_BYTEENABLE,
   output logic      [31:0]           O_AVS_READDATA,
   output logic                       O_AVS_WAITREQUEST,
   output logic      [1:0]            O_AVS_RESPONSE,
   // lcd timing logic, same clock
   input  wire logic [31:0]           I_LCD_SEGMENT,
   input  wire logic [3:0]            I_LCD_COMMON,
   input  wire logic [2:0]            I_LCD_COM_SELECT,
   // package pins, d e f g packed as port * 8 + bit
   input  wire logic [31:0]           I_PIN_IN,
   output logic      [31:0]           O_PIN_OUT,
   output logic      [31:0]           O_PIN_OE,
   output logic      [31:0]           O_LCD_OWNED
);

   // ==================================================================
   // elaboration checks
   if (ADDR_WIDTH < 11) begin : g_addr_check
      $error("ADDR_WIDTH must cover byte address 0x620");
   end

   // ==================================================================
   // state and decode
   lcd_io_pkg::state_t state;
   lcd_io_pkg::state_t next_state;
   lcd_io_pkg::pin_vec_t lcd_level;
   lcd_io_pkg::pin_vec_t owned;

   logic [8:0] index;
   logic       aligned;
   logic       request;
   logic       take;

   assign index   = I_AVS_ADDRESS[10:2];
   assign aligned = (I_AVS_ADDRESS[1:0] == 2'h0);
   assign request = I_AVS_READ | I_AVS_WRITE;
   // a request is taken at the edge where waitrequest is seen low
   assign take    = request & ~state.waitreq;

   // ==================================================================
   // per-pin ownership and lcd drive level
   for (genvar p = 0; p < lcd_io_pkg::PIN_COUNT; p++) begin : g_pin
      // enable bit of the pin's group decides lcd or port ownership
      assign owned.lane[p] = state.seg_en[lcd_io_pkg::PIN_GROUP[p]]; // RULE7 RULE10 RULE11
      if (p >= lcd_io_pkg::COM_PIN_BASE && p < 8) begin : g_com
         // d5..d7 carry a common when the lcd logic asks for it
         assign lcd_level.lane[p] = I_LCD_COM_SELECT[p - lcd_io_pkg::COM_PIN_BASE]
            ? I_LCD_COMMON[lcd_io_pkg::PIN_COMMON[p - lcd_io_pkg::COM_PIN_BASE]]
            : I_LCD_SEGMENT[lcd_io_pkg::PIN_SEGMENT[p]]; // RULE2
      end else begin : g_seg
         assign lcd_level.lane[p] = I_LCD_SEGMENT[lcd_io_pkg::PIN_SEGMENT[p]]; // RULE1 RULE3 RULE4 RULE5
      end
   end

   // ==================================================================
   // next-state logic
   always_comb begin
      logic [7:0] rd_byte;
      logic       hit;
      logic [1:0] port;
      logic       is_dir;
      logic       is_pins;
      rd_byte = 8'h00;
      hit     = 1'b1;
      port    = 2'h0;
      is_dir  = 1'b0;
      is_pins = 1'b0;
      next_state = state;

      // two-stage synchroniser for the pad levels
      next_state.sync1 = I_PIN_IN;
      next_state.sync2 = state.sync1;

      // register decode
      case (index)
         lcd_io_pkg::IDX_PORT_D_PINS: begin
            port    = 2'(lcd_io_pkg::PORT_D);
            is_pins = 1'b1;
         end
         lcd_io_pkg::IDX_PORT_E_PINS: begin
            port    = 2'(lcd_io_pkg::PORT_E);
            is_pins = 1'b1;
         end
         lcd_io_pkg::IDX_PORT_F_PINS: begin
            port    = 2'(lcd_io_pkg::PORT_F);
            is_pins = 1'b1;
         end
         lcd_io_pkg::IDX_PORT_G_PINS: begin
            port    = 2'(lcd_io_pkg::PORT_G);
            is_pins = 1'b1;
         end
         lcd_io_pkg::IDX_PORT_D_DIRECTION: begin
            port   = 2'(lcd_io_pkg::PORT_D);
            is_dir = 1'b1;
         end
         lcd_io_pkg::IDX_PORT_E_DIRECTION: begin
            port   = 2'(lcd_io_pkg::PORT_E);
            is_dir = 1'b1;
         end
         lcd_io_pkg::IDX_PORT_F_DIRECTION: begin
            port   = 2'(lcd_io_pkg::PORT_F);
            is_dir = 1'b1;
         end
         lcd_io_pkg::IDX_PORT_G_DIRECTION: begin
            port   = 2'(lcd_io_pkg::PORT_G);
            is_dir = 1'b1;
         end
         lcd_io_pkg::IDX_SEGMENT_PIN_EN: begin
            port = 2'h0;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      hit = hit & aligned;

      // read mux: data reads see the pins, not the latch, so a
      // bit-modify sequence writes pin levels back into input bits
      if (is_pins) begin
         rd_byte = state.sync2[port * 8 +: 8]; // RULE14 RULE16
      end else if (is_dir) begin
         rd_byte = state.direction[port];
      end else begin
         rd_byte = state.seg_en;
      end

      // bus handshake: one wait cycle, then a one-cycle answer
      next_state.waitreq = ~(request & state.waitreq);
      if (request & state.waitreq) begin
         next_state.rdata = (hit & I_AVS_READ) ? {24'h000000, rd_byte} : 32'h00000000;
         next_state.resp  = hit ? lcd_io_pkg::RESP_OKAY : lcd_io_pkg::RESP_SLVERR;
      end

      // writes land on the edge that ends the request
      if (take & I_AVS_WRITE & hit & I_AVS_BYTEENABLE[0]) begin
         if (is_pins) begin
            next_state.latch[port] = I_AVS_WRITEDATA[7:0]; // RULE15
         end else if (is_dir) begin
            next_state.direction[port] = I_AVS_WRITEDATA[7:0];
         end else begin
            next_state.seg_en = I_AVS_WRITEDATA[7:0]; // RULE8 RULE9
         end
      end

      // pin drivers, registered so the pads see clean levels
      for (int p = 0; p < lcd_io_pkg::PIN_COUNT; p++) begin
         if (owned.lane[p]) begin
            // lcd owns the pad whatever the direction bit says
            next_state.pin_oe[p]  = 1'b1; // RULE6 RULE7
            next_state.pin_out[p] = lcd_level.lane[p];
         end else if (p < lcd_io_pkg::BIDIR_PINS) begin
            // d0..d4 in digital mode: direction set means input
            next_state.pin_oe[p]  = ~state.direction[lcd_io_pkg::PORT_D][p]; // RULE17 RULE18
            next_state.pin_out[p] = state.latch[lcd_io_pkg::PORT_D][p];
         end else begin
            // input-only pads ignore direction and latch alike
            next_state.pin_oe[p]  = 1'b0; // RULE19
            next_state.pin_out[p] = 1'b0;
         end
      end
      next_state.lcd_owned = owned.lane;
   end

   // ==================================================================
   // state register; reset hands every shared pad to the lcd
   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state.direction <= {4{lcd_io_pkg::RST_DIRECTION}};  // RULE12
         state.latch     <= {4{lcd_io_pkg::RST_PINS_LATCH}}; // RULE13
         state.seg_en    <= lcd_io_pkg::RST_SEG_ENABLE;      // RULE6 RULE9
         state.sync1     <= 32'h00000000;
         state.sync2     <= 32'h00000000;
         state.waitreq   <= 1'b1; // busy while in reset
         state.rdata     <= 32'h00000000;
         state.resp      <= lcd_io_pkg::RESP_OKAY;
         state.pin_out   <= 32'h00000000;
         state.pin_oe    <= 32'hFFFFFFFF; // lcd drives from reset on
         state.lcd_owned <= 32'hFFFFFFFF;
      end else begin
         state <= next_state;
      end
   end

   // ==================================================================
   // outputs straight from flops
   assign O_AVS_READDATA    = state.rdata;
   assign O_AVS_WAITREQUEST = state.waitreq; // high idle, low one cycle per request
   assign O_AVS_RESPONSE    = state.resp;
   assign O_PIN_OUT         = state.pin_out;
   assign O_PIN_OE          = state.pin_oe;
   assign O_LCD_OWNED       = state.lcd_owned;

endmodule

`default_nettype wire

// ===== verification/lcd_io_checker.sv
// assertions on bus handshake and pin ownership of the shared i/o ports
// assumes registers change only through completed bus writes
`timescale 1ns/100ps
`default_nettype none
module lcd_io_checker #(parameter int ADDR_WIDTH = 11) (
   // bus side
   input wire logic                  I_MCLK,
   input wire logic                  I_NRST,
   input wire logic [ADDR_WIDTH-1:0] I_AVS_ADDRESS,
   input wire logic                  I_AVS_READ,
   input wire logic                  I_AVS_WRITE,
   input wire logic [31:0]           I_AVS_WRITEDATA,
   input wire logic [3:0]            I_AVS_BYTEENABLE,
   input wire logic [31:0]           O_AVS_READDATA,
   input wire logic                  O_AVS_WAITREQUEST,
   // lcd and pad side
   input wire logic [31:0]           I_LCD_SEGMENT,
   input wire logic [3:0]            I_LCD_COMMON,
   input wire logic [2:0]            I_LCD_COM_SELECT,
   input wire logic [31:0]           O_PIN_OUT,
   input wire logic [31:0]           O_PIN_OE,
   input wire logic [31:0]           O_LCD_OWNED
);
   logic [7:0]  lcd_segment_output, dir_d, lat_d, wd;
   logic [31:0] own, lcd;
   logic [10:0] wa;
   logic        wr_done;
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_NRST);
   // ==================================================================
   // shadow registers: a write with lane 0 off must not count
   assign wa = I_AVS_ADDRESS[10:0];
   assign wd = I_AVS_WRITEDATA[7:0];
   assign wr_done = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0];
   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         lcd_segment_output <= 8'hFF;
         dir_d <= 8'hFF;
         lat_d <= 8'h00;
      end else if (wr_done && wa == 11'h434) lcd_segment_output <= wd;
      else if (wr_done && wa == 11'h220) dir_d <= wd;
      else if (wr_done && wa == 11'h020) lat_d <= wd;
   end
   // owner and lcd level each pad should show
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         own[i] = lcd_segment_output[lcd_io_pkg::PIN_GROUP[i]];
         lcd[i] = I_LCD_SEGMENT[lcd_io_pkg::PIN_SEGMENT[i]];
      end
      for (int k = 0; k < 3; k++)
         if (I_LCD_COM_SELECT[k]) lcd[5 + k] = I_LCD_COMMON[lcd_io_pkg::PIN_COMMON[k]];
   end
   // ==================================================================
   // properties
   property p_wait_once;
      (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST; endproperty
   a_wait_once: assert property (p_wait_once) else $error("request not answered");
   property p_wait_pulse; !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
   property p_owned_map; O_LCD_OWNED == $past(own); endproperty
   a_owned_map: assert property (p_owned_map) else $error("pad owner wrong");
   property p_owned_oe; (O_PIN_OE & O_LCD_OWNED) == O_LCD_OWNED; endproperty
   a_owned_oe: assert property (p_owned_oe) else $error("lcd pad not driven");
   property p_lcd_level; $past(I_NRST) |-> ((O_PIN_OUT ^ $past(lcd)) & O_LCD_OWNED) == 32'h0;
   endproperty
   a_lcd_level: assert property (p_lcd_level) else $error("lcd level wrong");
   // the latch reaches the pad stage on input pins too; only oe gates it
   property p_port_d_dir; !O_LCD_OWNED[0] |-> O_PIN_OE[4:0] == ~$past(dir_d[4:0])
      && O_PIN_OUT[4:0] == $past(lat_d[4:0]); endproperty
   a_port_d_dir: assert property (p_port_d_dir) else $error("port d drive wrong");
   property p_input_only; (O_PIN_OE & ~O_LCD_OWNED & 32'hFFFF_FFE0) == 32'h0; endproperty
   a_input_only: assert property (p_input_only) else $error("input pad driven");
   property p_seg_read; I_AVS_READ && !O_AVS_WAITREQUEST && wa == 11'h434
      |-> O_AVS_READDATA == {24'h0, lcd_segment_output}; endproperty
   a_seg_read: assert property (p_seg_read) else $error("enable readback wrong");
endmodule
bind lcd_shared_io_ports lcd_io_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_lcd_io_checker (.*);
`default_nettype wire

// ===== verification/lcd_pad_model.sv
// pads and outside circuit: the block wins wherever it drives
// assumes the bench sets the level the outside puts on a free pad
`timescale 1ns/100ps
`default_nettype none
module lcd_pad_model (
   // block drive and outside level
   input  wire logic [31:0] i_oe,
   input  wire logic [31:0] i_out,
   input  wire logic [31:0] i_ext,
   // resolved level
   output logic      [31:0] o_pad
);
   // ==================================================================
   // no keeper: a released pad follows the outside at once
   assign o_pad = (i_oe & i_out) | (~i_oe & i_ext);
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the lcd shared i/o ports
// assumes package, design, pad model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct packed {logic [2:0] c; logic [10:0] a; logic [9:0] e;} row_t;
   logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, wreq;
   logic [10:0] addr = 11'h000;
   logic [31:0] wdat = 32'h0, rdat, pout, poe, own, pad;
   logic [31:0] lcd_segment_output = 32'h9A5C_36E1, ext = 32'h3C96_5AE7;
   logic [3:0]  be = 4'hF, lcd_common_output = 4'h6;
   logic [2:0]  csel = 3'h0;
   logic [1:0]  resp, r;
   logic [7:0]  q;
   int          n_fail = 0, compares = 0;
   // reset values, refused places, then lcd levels on every port
   row_t rows [12] = '{'{3'h0, 11'h220, 10'h0FF}, '{3'h0, 11'h224, 10'h0FF},
      '{3'h0, 11'h61C, 10'h0FF}, '{3'h0, 11'h620, 10'h0FF}, '{3'h0, 11'h434, 10'h0FF},
      '{3'h0, 11'h7FC, 10'h200}, '{3'h0, 11'h222, 10'h200}, '{3'h0, 11'h020, 10'h081},
      '{3'h0, 11'h024, 10'h0B7}, '{3'h0, 11'h41C, 10'h0C3}, '{3'h0, 11'h420, 10'h0A5},
      '{3'h7, 11'h020, 10'h0C1}};
   always #5 clk = ~clk;
   lcd_shared_io_ports #(.ADDR_WIDTH(11)) i_lcd_shared_io_ports (
      .I_MCLK(clk), .I_NRST(nrst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(be),
      .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq), .O_AVS_RESPONSE(resp),
      .I_LCD_SEGMENT(lcd_segment_output), .I_LCD_COMMON(lcd_common_output), .I_LCD_COM_SELECT(csel),
      .I_PIN_IN(pad), .O_PIN_OUT(pout), .O_PIN_OE(poe), .O_LCD_OWNED(own));
   lcd_pad_model i_lcd_pad_model (.i_oe(poe), .i_out(pout), .i_ext(ext), .o_pad(pad));
   // ==================================================================
   // tasks
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic [10:0] a, input logic w, input logic [7:0] d,
                      input logic [3:0] b);
      int k;
      k = 0;
      addr <= a;
      rd <= !w;
      wr <= w;
      wdat <= {24'h0, d};
      be <= b;
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 20);
      if (wreq !== 1'b0) begin
         n_fail++;
         $display("Error at %0t: no answer from %h", $time, a);
         report_and_stop();
      end
      q = rdat[7:0];
      r = resp;
      rd <= 1'b0;
      wr <= 1'b0;
      // one idle edge, so a following call never re-raises a strobe in this step
      @(posedge clk);
   endtask
   // pads need the output stage and two sync flops to settle
   task automatic rdchk(input logic [10:0] a, input logic [9:0] e);
      repeat (4) @(posedge clk);
      bus(a, 1'b0, 8'h00, 4'hF);
      compares++;
      if ({r, q} !== e) begin
         n_fail++;
         $display("Error at %0t: read %h gave %h not %h", $time, a, {r, q}, e);
      end
   endtask
   // ==================================================================
   // sequence
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      foreach (rows[n]) begin
         csel <= rows[n].c;
         rdchk(rows[n].a, rows[n].e);
      end
      bus(11'h434, 1'b1, 8'h9F, 4'hF);
      rdchk(11'h420, 10'h03C);
      rdchk(11'h024, 10'h037);
      bus(11'h434, 1'b1, 8'hB9, 4'hF);
      rdchk(11'h024, 10'h05A);
      rdchk(11'h420, 10'h025);
      bus(11'h434, 1'b1, 8'h00, 4'hF);
      rdchk(11'h41C, 10'h096);
      rdchk(11'h020, 10'h0E7);
      bus(11'h020, 1'b1, q | 8'h08, 4'hF);
      bus(11'h220, 1'b1, 8'hE0, 4'hF);
      rdchk(11'h020, 10'h0EF);
      bus(11'h020, 1'b1, 8'h15, 4'h0);
      rdchk(11'h020, 10'h0EF);
      bus(11'h020, 1'b1, 8'h15, 4'hF);
      rdchk(11'h020, 10'h0F5);
      bus(11'h434, 1'b1, 8'h01, 4'hF);
      rdchk(11'h020, 10'h0E1);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      compares++;
      if (own !== 32'hFFFFFFFF) begin
         n_fail++;
         $display("Error at %0t: pads not handed to lcd in reset", $time);
      end
      nrst <= 1'b1;
      rdchk(11'h434, 10'h0FF);
      rdchk(11'h220, 10'h0FF);
      bus(11'h434, 1'b1, 8'h00, 4'hF);
      bus(11'h220, 1'b1, 8'hE0, 4'hF);
      rdchk(11'h020, 10'h0E0);
      report_and_stop();
   end
endmodule
`default_nettype wire
